// ---- design/pcr_pkg.sv ----
// pcr_pkg: constants and carriers for the pad cell cluster
// assumes one core clock and APB register access
package pcr_pkg;
  localparam int CELLS = 6;
  localparam int ROW_CELLS = 4;
  localparam int SHARED = 4;
  // word indices; byte address is four times the index
  localparam logic [5:0] CFG_IDX = 6'h00;
  localparam logic [5:0] INV_IDX = 6'h06;
  localparam logic [5:0] CTRL_IDX = 6'h0c;
  localparam logic [5:0] PIN_IDX = 6'h0d;
  localparam logic [5:0] CAP_IDX = 6'h0e;
  localparam logic [23:0] CFG_RESET = 24'h00_0000;
  localparam logic [7:0] INV_RESET = 8'h00;
  localparam logic CTRL_RESET = 1'b0;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    SRC_SH0 = 3'b000,
    SRC_SH1 = 3'b001,
    SRC_SH2 = 3'b010,
    SRC_SH3 = 3'b011,
    SRC_CELL = 3'b100
  } pcr_src_t;

  typedef struct packed {
    logic [SHARED-1:0] oe;
    logic [SHARED-1:0] ce;
    logic [SHARED-1:0] clk;
    logic [SHARED-1:0] clr;
  } pcr_shared_t;

  typedef struct packed {
    logic dataA;
    logic dataB;
    logic oe;
    logic ceIn;
    logic ceOut;
    logic clk;
    logic clr;
  } pcr_lines_t;

  typedef struct packed {
    logic ddrIn;
    logic ddrOut;
    logic presetMode;
    pcr_src_t selClkOut;
    pcr_src_t selClkIn;
    pcr_src_t selSclr;
    pcr_src_t selAclr;
    pcr_src_t selCeOut;
    pcr_src_t selCeIn;
    pcr_src_t selOe;
  } pcr_cfg_t;

  typedef struct packed {
    logic pin;
    logic clr;
    logic clk;
    logic ceOut;
    logic ceIn;
    logic oe;
    logic dataB;
    logic dataA;
  } pcr_inv_t;

  typedef struct packed {
    logic pin;
    logic dA;
    logic dB;
    logic oe;
    logic ceIn;
    logic ceOut;
    logic aclr;
    logic sclr;
    logic clkIn;
    logic clkOut;
  } pcr_strobe_t;

  typedef struct packed {
    logic pinOut;
    logic pinOe;
    logic capA;
    logic capB;
    logic capL;
  } pcr_cellout_t;
endpackage : pcr_pkg

// ---- design/pcr_pad_cell.sv ----
// pcr_pad_cell: the six registers and input latch of one pad cell
// assumes strobes already selected, inverted and synchronised to core_clk
`timescale 1ns/1ps
`default_nettype none
module pcr_pad_cell import pcr_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire pcr_strobe_t st,
  input wire logic ddrOut,
  input wire logic initVal,
  output pcr_cellout_t co
);
  logic prevIn;
  logic prevOut;
  logic inA;
  logic inB;
  logic inL;
  logic outA;
  logic outB;
  logic oePos;
  logic oeNeg;
  logic riseIn;
  logic fallIn;
  logic riseOut;
  logic fallOut;
  logic actIn;
  logic actOut;

  // cell clocks are oversampled, so edges are detected levels
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prevIn <= 1'b0;
      prevOut <= 1'b0;
    end else begin
      prevIn <= st.clkIn;
      prevOut <= st.clkOut;
    end
  end
  assign riseIn = st.clkIn & ~prevIn;
  assign fallIn = ~st.clkIn & prevIn;
  assign riseOut = st.clkOut & ~prevOut;
  assign fallOut = ~st.clkOut & prevOut;
  // sync clear acts on the edge even while the enable is low
  assign actIn = st.ceIn | st.sclr;
  assign actOut = st.ceOut | st.sclr;

  // input capture: rising, falling and the latch
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      inA <= 1'b0;
      inB <= 1'b0;
      inL <= 1'b0;
    end else if (st.aclr) begin
      inA <= initVal;
      inB <= initVal;
      inL <= initVal;
    end else begin
      if (riseIn & actIn) begin
        inA <= st.sclr ? initVal : st.pin;
      end
      if (fallIn & actIn) begin
        inB <= st.sclr ? initVal : st.pin;
        inL <= st.sclr ? initVal : inA;
      end
    end
  end

  // output and enable registers share one clock and enable
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      outA <= 1'b0;
      outB <= 1'b0;
      oePos <= 1'b0;
      oeNeg <= 1'b0;
    end else if (st.aclr) begin
      outA <= initVal;
      outB <= initVal;
      oePos <= initVal;
      oeNeg <= initVal;
    end else begin
      if (riseOut & actOut) begin
        outA <= st.sclr ? initVal : st.dA;
        outB <= st.sclr ? initVal : st.dB;
        oePos <= st.sclr ? initVal : st.oe;
      end
      if (fallOut & actOut) begin
        oeNeg <= st.sclr ? initVal : oePos;
      end
    end
  end

  // pin mux: in double rate, high phase shows outA, low phase outB; single rate always shows outA
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      co <= '0;
    end else begin
      co.pinOut <= (ddrOut & ~st.clkOut) ? outB : outA;
      co.pinOe <= ddrOut ? (oePos & oeNeg) : oePos;
      co.capA <= inA;
      co.capB <= inB;
      co.capL <= inL;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence noFallYet;
    ddrOut && !oeNeg && !fallOut && !st.aclr;
  endsequence
  // power-up level may change while the clear is held; compare with the level seen at the edge
  AST_ACLR: assert property (st.aclr |=> outA == $past(initVal) && inL == $past(initVal) && oeNeg == $past(initVal)) else $error("async clear lost");
  AST_HOLD: assert property (riseOut && !st.ceOut && !st.sclr && !st.aclr |=> $stable(outA) && $stable(outB)) else $error("output moved while disabled");
  AST_LOAD: assert property (riseOut && st.ceOut && !st.sclr && !st.aclr |=> outA == $past(st.dA) && outB == $past(st.dB)) else $error("output not loaded");
  AST_SCLR: assert property (riseIn && st.sclr && !st.aclr |=> inA == $past(initVal)) else $error("sync clear missed");
  AST_NEGOE: assert property (noFallYet [*2] |-> !co.pinOe) else $error("enable before falling edge");
endmodule : pcr_pad_cell
`default_nettype wire

// ---- design/pcr_io_block.sv ----
// pcr_io_block: register cluster of one pad_cell group with APB control
// assumes logic_cluster lines and pins are asynchronous to core_clk
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcr_io_block import pcr_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pcr_shared_t sharedLines,
  input wire pcr_lines_t [CELLS-1:0] cellLines,
  input wire logic [CELLS-1:0] padIn,
  output logic [CELLS-1:0] padOut,
  output logic [CELLS-1:0] padOe,
  output logic [2*CELLS-1:0] colRoute,
  output logic [2*CELLS-1:0] rowRoute,
  output logic [2*CELLS-1:0] directLink
);
  localparam int SYNC_W = $bits(pcr_shared_t) + CELLS * $bits(pcr_lines_t) + CELLS;

  logic [SYNC_W-1:0] syncMeta;
  logic [SYNC_W-1:0] syncOut;
  pcr_shared_t sh;
  pcr_lines_t [CELLS-1:0] ln;
  logic [CELLS-1:0] pinS;
  pcr_cfg_t [CELLS-1:0] cellCfg;
  pcr_inv_t [CELLS-1:0] cellInv;
  pcr_strobe_t [CELLS-1:0] st;
  pcr_cellout_t [CELLS-1:0] co;
  logic [CELLS-1:0] active;
  logic rowBlock;
  logic [5:0] wordIdx;
  logic addrHit;
  logic readOnly;
  logic wrEn;
  logic [31:0] next_prdata;
  logic [3*CELLS-1:0] capView;

  // all cell lines and pins cross in two flops before use
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      syncMeta <= '0;
      syncOut <= '0;
    end else begin
      syncMeta <= {sharedLines, cellLines, padIn};
      syncOut <= syncMeta;
    end
  end
  assign {sh, ln, pinS} = syncOut;

  // APB decode
  assign wordIdx = paddr[7:2];
  assign addrHit = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00) && (wordIdx <= CAP_IDX);
  assign readOnly = wordIdx >= PIN_IDX;
  assign wrEn = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (wordIdx == CTRL_IDX) begin
      next_prdata = {31'h0000_0000, rowBlock};
    end else if (wordIdx == PIN_IDX) begin
      next_prdata = {14'h0000, padOe, padOut, pinS};
    end else if (wordIdx == CAP_IDX) begin
      next_prdata = {14'h0000, capView};
    end else if (wordIdx >= INV_IDX && wordIdx < CTRL_IDX) begin
      next_prdata = {24'h00_0000, cellInv[3'(wordIdx - INV_IDX)]};
    end else if (wordIdx < INV_IDX) begin
      next_prdata = {8'h00, cellCfg[3'(wordIdx - CFG_IDX)]};
    end
  end

  // answer in the first access cycle; errors on unmapped accesses or read-only writes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      pready <= 1'b1;
      pslverr <= ~addrHit | (pwrite & readOnly);
      prdata <= (addrHit & ~pwrite) ? next_prdata : 32'h0000_0000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // row mode limits the group to four cells
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rowBlock <= CTRL_RESET;
    end else if (wrEn && wordIdx == CTRL_IDX) begin
      rowBlock <= pwdata[0];
    end
  end

  function automatic logic pick(input logic [SHARED-1:0] shr, input logic own,
                                input pcr_src_t sel);
    unique case (sel)
      SRC_SH0: pick = shr[0];
      SRC_SH1: pick = shr[1];
      SRC_SH2: pick = shr[2];
      SRC_SH3: pick = shr[3];
      SRC_CELL: pick = own;
      default: pick = 1'b0;
    endcase
  endfunction : pick

  genvar g;
  generate
    for (g = 0; g < CELLS; g++) begin : gCell
      // 28 lines feed four cells in row mode, 42 feed six otherwise
      assign active[g] = ~rowBlock | (g < ROW_CELLS);

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          cellCfg[g] <= CFG_RESET;
          cellInv[g] <= INV_RESET;
        end else if (wrEn) begin
          if (wordIdx == CFG_IDX + 6'(g)) begin
            cellCfg[g] <= pwdata[23:0];
          end
          if (wordIdx == INV_IDX + 6'(g)) begin
            cellInv[g] <= pwdata[7:0];
          end
        end
      end

      // async and sync clear each select their own source; both feed every register of the cell
      always_comb begin
        st[g].pin = pinS[g] ^ cellInv[g].pin;
        st[g].dA = ln[g].dataA ^ cellInv[g].dataA;
        st[g].dB = ln[g].dataB ^ cellInv[g].dataB;
        st[g].oe = pick(sh.oe, ln[g].oe, cellCfg[g].selOe) ^ cellInv[g].oe;
        st[g].ceIn = pick(sh.ce, ln[g].ceIn, cellCfg[g].selCeIn) ^ cellInv[g].ceIn;
        st[g].ceOut = pick(sh.ce, ln[g].ceOut, cellCfg[g].selCeOut) ^ cellInv[g].ceOut;
        st[g].aclr = pick(sh.clr, ln[g].clr, cellCfg[g].selAclr) ^ cellInv[g].clr;
        st[g].sclr = pick(sh.clr, ln[g].clr, cellCfg[g].selSclr) ^ cellInv[g].clr;
        st[g].clkIn = pick(sh.clk, ln[g].clk, cellCfg[g].selClkIn) ^ cellInv[g].clk;
        st[g].clkOut = pick(sh.clk, ln[g].clk, cellCfg[g].selClkOut) ^ cellInv[g].clk;
      end

      pcr_pad_cell uCell (
        .core_clk(core_clk),
        .reset(reset),
        .st(st[g]),
        .ddrOut(cellCfg[g].ddrOut),
        .initVal(cellCfg[g].presetMode),
        .co(co[g])
      );

      assign capView[3*g +: 3] = {co[g].capL, co[g].capB, co[g].capA};

      // unused cells stay tri-stated and silent
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          padOut[g] <= 1'b0;
          padOe[g] <= 1'b0;
        end else begin
          padOut[g] <= active[g] & co[g].pinOut;
          padOe[g] <= active[g] & co[g].pinOe;
        end
      end

      // double rate presents latch and falling capture as one pair
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          colRoute[2*g +: 2] <= 2'b00;
          rowRoute[2*g +: 2] <= 2'b00;
          directLink[2*g +: 2] <= 2'b00;
        end else begin
          if (!active[g]) begin
            colRoute[2*g +: 2] <= 2'b00;
          end else if (cellCfg[g].ddrIn) begin
            colRoute[2*g +: 2] <= {co[g].capL, co[g].capB};
          end else begin
            colRoute[2*g +: 2] <= {1'b0, co[g].capA};
          end
          if (rowBlock & active[g]) begin
            rowRoute[2*g +: 2] <= cellCfg[g].ddrIn ? {co[g].capL, co[g].capB} : {1'b0, co[g].capA};
            directLink[2*g +: 2] <= cellCfg[g].ddrIn ? {co[g].capL, co[g].capB} : {1'b0, co[g].capA};
          end else begin
            rowRoute[2*g +: 2] <= 2'b00;
            directLink[2*g +: 2] <= 2'b00;
          end
        end
      end

      AST_SEL_OWN: assert property (@(posedge core_clk) disable iff (reset) cellCfg[g].selOe == SRC_CELL && !cellInv[g].oe |-> st[g].oe == ln[g].oe) else $error("own enable not selected");
      AST_SEL_SHARED: assert property (@(posedge core_clk) disable iff (reset) cellCfg[g].selClkIn == SRC_SH2 && !cellInv[g].clk |-> st[g].clkIn == sh.clk[2]) else $error("shared clock not selected");
      AST_INVERT: assert property (@(posedge core_clk) disable iff (reset) cellInv[g].pin |-> st[g].pin != pinS[g]) else $error("pin not inverted");
      AST_DDR_ROUTE: assert property (@(posedge core_clk) disable iff (reset) cellCfg[g].ddrIn && active[g] |=> colRoute[2*g +: 2] == $past({co[g].capL, co[g].capB})) else $error("double rate pair wrong");
    end
  endgenerate

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence apbSetup;
    psel && !penable;
  endsequence
  AST_PREADY: assert property (apbSetup |=> pready ##1 !pready) else $error("ready not one access cycle");
  AST_CTRL_WRITE: assert property (wrEn && wordIdx == CTRL_IDX |=> rowBlock == $past(pwdata[0])) else $error("row mode write lost");
  AST_ROW_QUIET: assert property (rowBlock |=> padOe[CELLS-1:ROW_CELLS] == '0) else $error("spare cell driving in row mode");
  AST_COL_ONLY: assert property (!rowBlock |=> rowRoute == '0 && directLink == '0) else $error("column group on row routing");
  AST_SYNC: assert property (1'b1 ##2 1'b1 |-> pinS == $past(padIn, 2)) else $error("pin sync depth wrong");
endmodule : pcr_io_block
`default_nettype wire

// ---- bench/pcr_far_side.sv ----
// pcr_far_side: logic_cluster lines and pad pins seen from outside the cells
// assumes requests change just after core_clk rising edges
`timescale 1ns/1ps
`default_nettype none
module pcr_far_side import pcr_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic pulse,
  input wire pcr_lines_t [CELLS-1:0] linesReq,
  input wire logic [CELLS-1:0] padOut,
  input wire logic [CELLS-1:0] padOe,
  input wire logic [CELLS-1:0] extEn,
  input wire logic [CELLS-1:0] extVal,
  output pcr_lines_t [CELLS-1:0] cellLines,
  output logic [CELLS-1:0] padIn,
  output logic busy
);
  logic [3:0] phase;
  logic [CELLS-1:0] lastPin;
  // cell clock stands low between pulses; 4 cycles a phase, above the 3 needed
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase <= 4'h0;
    end else if (phase != 4'h0) begin
      phase <= phase - 4'h1;
    end else if (pulse) begin
      phase <= 4'h8;
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lastPin <= '0;
    end else begin
      lastPin <= padIn;
    end
  end
  assign busy = (phase != 4'h0) || pulse;
  always_comb begin
    cellLines = linesReq;
    for (int i = 0; i < CELLS; i++) begin
      cellLines[i].clk = linesReq[i].clk ^ (phase > 4'h4);
    end
  end
  // floating pin shows no stale level: it flips every cycle
  assign padIn = (padOe & padOut) | (~padOe & extEn & extVal) | (~padOe & ~extEn & ~lastPin);
endmodule : pcr_far_side
`default_nettype wire

// ---- bench/pcr_io_block_bench.sv ----
// pcr_io_block_bench: self-checking bench for the pad cell register cluster
// assumes pcr_pkg and pcr_io_block; pins and cell lines from pcr_far_side
`timescale 1ns/1ps
`default_nettype none
module pcr_io_block_bench import pcr_pkg::*;;
  localparam logic [2:0] CL = 3'h4;
  localparam logic [2:0] KZ = 3'h5;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, pulse, busy, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, w, v;
  pcr_shared_t sharedLines;
  pcr_lines_t [CELLS-1:0] lines, cellLines;
  logic [CELLS-1:0] padIn, padOut, padOe, extEn, extVal;
  logic [2*CELLS-1:0] colRoute, rowRoute;
  int nErrors, checkCount, cycles;
  logic [11:0] badA [5] = '{12'h03c, 12'h002, 12'h100, 12'h034, 12'h038};
  logic badW [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  pcr_io_block dut_u (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sharedLines(sharedLines), .cellLines(cellLines), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .colRoute(colRoute), .rowRoute(rowRoute),
    .directLink());
  pcr_far_side far_u (.core_clk(core_clk), .reset(reset), .pulse(pulse), .linesReq(lines),
    .padOut(padOut), .padOe(padOe), .extEn(extEn), .extVal(extVal),
    .cellLines(cellLines), .padIn(padIn), .busy(busy));
  always #2.5 core_clk = ~core_clk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one idle edge first, so release and next setup never share a time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", exp, r);
    chk("pslverr", 32'h0000_0000, {31'h0, e});
  endtask : rd
  task automatic clkPulse();
    int n;
    n = 0;
    pulse <= 1'b1;
    @(posedge core_clk);
    pulse <= 1'b0;
    while (busy === 1'b1 && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    repeat (8) @(posedge core_clk);
  endtask : clkPulse
  function automatic logic [31:0] cfgw(input logic [2:0] oe, ceI, ceO, ac, sc, ckI, ckO,
    input logic pre);
    return {10'h000, pre, ckO, ckI, sc, ac, ceO, ceI, oe};
  endfunction : cfgw
  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sharedLines = '0;
    lines = '0;
    extEn = '0;
    extVal = '0;
    pulse = 1'b0;
    nErrors = 0;
    checkCount = 0;
    cycles = 0;
    w = $urandom(75073);
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    for (int g = 0; g < CELLS; g++) begin
      rd(12'(4*g), 32'h0000_0000);
      rd(12'(24+4*g), 32'h0000_0000);
    end
    rd(12'h030, 32'h0000_0000);
    for (int g = 0; g < CELLS; g++) begin
      w = $urandom() & 32'h00ff_ffff;
      v = $urandom() & 32'h0000_00ff;
      sharedLines <= 16'($urandom());
      lines[g] <= 7'($urandom());
      extEn <= 6'($urandom()) & 6'h3e;
      extVal <= 6'($urandom());
      wr(12'(4*g), w);
      wr(12'(24+4*g), v);
      rd(12'(4*g), w);
      rd(12'(24+4*g), v);
    end
    for (int i = 0; i < 5; i++) begin
      apb(badW[i], badA[i], 32'hffff_ffff, r, e);
      chk("pslverr", 32'h0000_0001, {31'h0, e});
    end
    // cell 0: enable and clock strobes from its own lines, both clears tied to constant zero
    lines[0] <= '0;
    wr(12'h018, 32'h0000_0000);
    wr(12'h000, cfgw(CL, CL, CL, KZ, KZ, CL, CL, 1'b0));
    lines[0].dataA <= 1'b1;
    lines[0].oe <= 1'b1;
    lines[0].ceOut <= 1'b1;
    clkPulse();
    chk("padOut", 32'h0000_0001, {31'h0, padOut[0]});
    chk("padOe", 32'h0000_0001, {31'h0, padOe[0]});
    lines[0].dataA <= 1'b0;
    lines[0].oe <= 1'b0;
    lines[0].ceOut <= 1'b0;
    clkPulse();
    chk("padOut", 32'h0000_0001, {31'h0, padOut[0]});
    chk("padOe", 32'h0000_0001, {31'h0, padOe[0]});
    wr(12'h018, 32'h0000_0005);
    lines[0].dataA <= 1'b1;
    lines[0].oe <= 1'b1;
    lines[0].ceOut <= 1'b1;
    clkPulse();
    chk("padOut", 32'h0000_0000, {31'h0, padOut[0]});
    chk("padOe", 32'h0000_0000, {31'h0, padOe[0]});
    wr(12'h018, 32'h0000_0000);
    clkPulse();
    chk("padOut", 32'h0000_0001, {31'h0, padOut[0]});
    wr(12'h000, cfgw(CL, CL, CL, KZ, CL, CL, CL, 1'b0));
    lines[0].clr <= 1'b1;
    lines[0].ceOut <= 1'b0;
    clkPulse();
    chk("padOut", 32'h0000_0000, {31'h0, padOut[0]});
    chk("padOe", 32'h0000_0000, {31'h0, padOe[0]});
    // the async clear line loads the preset into the output registers, even across a pulse
    lines[0].clr <= 1'b0;
    wr(12'h000, cfgw(CL, CL, CL, CL, KZ, CL, CL, 1'b1));
    lines[0].dataA <= 1'b0;
    lines[0].oe <= 1'b0;
    lines[0].ceOut <= 1'b1;
    lines[0].clr <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("padOut", 32'h0000_0001, {31'h0, padOut[0]});
    clkPulse();
    chk("padOut", 32'h0000_0001, {31'h0, padOut[0]});
    wr(12'h000, cfgw(CL, CL, CL, CL, KZ, CL, CL, 1'b0));
    repeat (8) @(posedge core_clk);
    chk("padOut", 32'h0000_0000, {31'h0, padOut[0]});
    chk("padOe", 32'h0000_0000, {31'h0, padOe[0]});
    lines[0].clr <= 1'b0;
    // output clock tied off, so only the capture side may move
    wr(12'h000, cfgw(CL, CL, CL, KZ, KZ, CL, KZ, 1'b0));
    extEn[0] <= 1'b1;
    extVal[0] <= 1'b1;
    lines[0].ceIn <= 1'b1;
    lines[0].dataA <= 1'b1;
    clkPulse();
    chk("padOut", 32'h0000_0000, {31'h0, padOut[0]});
    apb(1'b0, 12'h038, 32'h0000_0000, r, e);
    chk("capA", 32'h0000_0001, {31'h0, r[0]});
    chk("colRoute", 32'h0000_0001, {30'h0, colRoute[1:0]});
    chk("rowRoute", 32'h0000_0000, {20'h0, rowRoute});
    // double rate out: clock idles low, so the pin shows the second register
    wr(12'h000, cfgw(CL, CL, CL, KZ, KZ, CL, CL, 1'b0) | 32'h0040_0000);
    lines[0].dataA <= 1'b1;
    lines[0].dataB <= 1'b0;
    lines[0].oe <= 1'b1;
    lines[0].ceOut <= 1'b1;
    clkPulse();
    chk("padOut", 32'h0000_0000, {31'h0, padOut[0]});
    chk("padOe", 32'h0000_0001, {31'h0, padOe[0]});
    lines[0].dataB <= 1'b1;
    clkPulse();
    chk("padOut", 32'h0000_0001, {31'h0, padOut[0]});
    chk("padOe", 32'h0000_0001, {31'h0, padOe[0]});
    wr(12'h030, 32'h0000_0001);
    repeat (8) @(posedge core_clk);
    chk("padOe", 32'h0000_0000, {30'h0, padOe[5:4]});
    chk("padOut", 32'h0000_0000, {30'h0, padOut[5:4]});
    chk("colRoute", 32'h0000_0000, {28'h0, colRoute[11:8]});
    conclude();
  end
endmodule : pcr_io_block_bench
`default_nettype wire
